// *** hdl/dac_load_mask_offset_pkg.sv ***
/*
  Constants and carrier types for the DAC load, interrupt gate and offset
  register bank. Assumes an 8-bit register address space reached over a
  plain strobe port on the single 200 MHz core clock.
*/
package dac_load_mask_offset_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_DAC_CONFIG        = 8'h1B;
  localparam logic [7:0] ADDR_DAC_LOAD_CMD      = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_GATE_ONE      = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_GATE_TWO      = 8'h1E;
  localparam logic [7:0] ADDR_INT_TEMP_CAL      = 8'h1F;
  localparam logic [7:0] ADDR_EXT_TEMP_CAL      = 8'h20;
  localparam logic [7:0] ADDR_INT_THERMAL_SHIFT = 8'h21;
  localparam logic [7:0] ADDR_CONTROL_THREE     = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS_ONE    = 8'h31;
  localparam logic [7:0] ADDR_IRQ_STATUS_TWO    = 8'h32;

  // ==========================================================================
  // Field positions
  localparam int LOAD_CMD_DAC_LSB   = 0;
  localparam int LOAD_CMD_REF_AB    = 4;
  localparam int LOAD_CMD_REF_CD    = 5;
  localparam int DAC_CFG_MODE_LSB   = 4;
  localparam int CTRL3_PIN_DISABLE  = 3;
  localparam int GATE_TWO_SUPPLY    = 4;

  // ==========================================================================
  // Values after reset, field codes and sizes
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_THERMAL_SHIFT  = 8'hD8;
  localparam logic [1:0] LOAD_MODE_REGISTER = 2'h3;
  localparam logic [1:0] REF_RESET          = 2'h0;
  localparam logic [7:0] DEADBAND_CODE      = 8'hFF;
  localparam logic [7:0] CODE_MIDSCALE_FLIP = 8'h80;
  localparam logic [7:0] GATE_TWO_USED      = 8'h10;
  localparam int         NUM_DACS           = 4;
  localparam int         SYNC_STAGES        = 2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] upper_limit_events;
    logic       supply_event;
  } limit_events_t;

endpackage : dac_load_mask_offset_pkg

// *** hdl/dac_load_mask_offset_regs.sv ***
/*
  Register bank for DAC software loading, reference selection, interrupt
  gating and temperature offsets, with sticky interrupt status and a level
  interrupt output. Assumes the bus master, comparators and converters run
  on clk_in; only the external load pin is asynchronous and is synchronised.
*/
// Functional notes
// - Load register DAC bits act only in software load mode
// - Per-DAC load bits always read back zero
// - Load bit N updates only DAC N
// - Bit 4 picks reference for DAC A/B
// - Bit 5 picks reference for DAC C/D
// - Gate one bits 0,1 mask internal limits
// - Gate one bit 2 masks external/input one
// - Gate one bit 3 masks external low
// - Gate one bit 4 masks sensor fault
// - Gate one bits 5-7 mask inputs two-four
// - Gate two bit 4 masks supply events
// - Internal offset added before store/compare
// - External offset added before store/compare
// - Thermal shift added before DAC A conversion
// - Out-of-span shifted temperature gives upper deadband
// - Load mode 11 means register-only updates
// - Control bit 3 disables the load pin
module dac_load_mask_offset_regs #(
  parameter int TEMP_W = 10
) (
  // Clock and reset
  input  wire logic                                    clk_in,
  input  wire logic                                    rst_n_in,
  // Register port
  input  wire dac_load_mask_offset_pkg::reg_req_t      req_in,
  output logic [7:0]                                   rdata_out,
  // Events from the limit comparators, one-cycle pulses
  input  wire dac_load_mask_offset_pkg::limit_events_t events_in,
  // External load pin, active low, asynchronous
  input  wire logic                                    load_pin_n_in,
  // Raw temperature results, quarter degree, two's complement
  input  wire logic signed [TEMP_W-1:0]                int_temp_raw_in,
  input  wire logic                                    int_temp_valid_in,
  input  wire logic signed [TEMP_W-1:0]                ext_temp_raw_in,
  input  wire logic                                    ext_temp_valid_in,
  // Corrected temperature results
  output logic signed [TEMP_W-1:0]                     int_temp_out,
  output logic                                         int_temp_valid_out,
  output logic signed [TEMP_W-1:0]                     ext_temp_out,
  output logic                                         ext_temp_valid_out,
  // DAC A thermal code and DAC control
  output logic [7:0]                                   dac_a_thermal_code_out,
  output logic [3:0]                                   dac_load_out,
  output logic [1:0]                                   ref_internal_out,
  // Interrupt
  output logic                                         irq_out
);

  // ==========================================================================
  // Declarations
  localparam int SUM_W = TEMP_W + 1;
  localparam logic signed [SUM_W-1:0] TEMP_MAX = SUM_W'((1 << (TEMP_W - 1)) - 1);
  localparam logic signed [SUM_W-1:0] TEMP_MIN = -SUM_W'(1 << (TEMP_W - 1));
  localparam int SYNC_STAGES_W = dac_load_mask_offset_pkg::SYNC_STAGES;

  logic [1:0]  load_mode_ff;
  logic        pin_disable_ff;
  logic [1:0]  ref_internal_ff;
  logic [7:0]  gate_one_ff;
  logic [7:0]  gate_two_ff;
  logic [7:0]  int_cal_ff;
  logic [7:0]  ext_cal_ff;
  logic [7:0]  thermal_shift_ff;
  logic [7:0]  status_one_ff;
  logic        status_two_ff;
  logic [7:0]  rdata_ff;
  logic [3:0]  dac_load_ff;
  logic [SYNC_STAGES_W-1:0] pin_sync_ff;
  logic        pin_last_ff;
  logic signed [TEMP_W-1:0] int_temp_ff;
  logic signed [TEMP_W-1:0] ext_temp_ff;
  logic        int_valid_ff;
  logic        ext_valid_ff;
  logic [7:0]  thermal_code_ff;

  logic        wr_load_cmd;
  logic        sw_load_enabled;
  logic        pin_fall;
  logic [3:0]  nxt_dac_load;
  logic [7:0]  clr_one;
  logic        clr_two;
  logic signed [SUM_W-1:0] int_sum;
  logic signed [SUM_W-1:0] ext_sum;
  logic signed [TEMP_W-1:0] int_corr;
  logic signed [TEMP_W-1:0] ext_corr;
  logic signed [9:0] shifted_deg;
  logic [7:0]  nxt_thermal_code;
  logic [7:0]  nxt_rdata;

  // ==========================================================================
  // Write decode
  assign wr_load_cmd = req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_DAC_LOAD_CMD);

  // Software loading needs the pin disabled and the register-only load mode
  assign sw_load_enabled = pin_disable_ff &&
                           (load_mode_ff == dac_load_mask_offset_pkg::LOAD_MODE_REGISTER);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_mode_ff <= dac_load_mask_offset_pkg::RST_ZERO[1:0];
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_DAC_CONFIG)) begin
      load_mode_ff <= req_in.wdata[dac_load_mask_offset_pkg::DAC_CFG_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_disable_ff <= 1'b0;
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_CONTROL_THREE)) begin
      pin_disable_ff <= req_in.wdata[dac_load_mask_offset_pkg::CTRL3_PIN_DISABLE];
    end
  end

  // Reference selection is held regardless of load mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_internal_ff <= dac_load_mask_offset_pkg::REF_RESET;
    end else if (wr_load_cmd) begin
      ref_internal_ff[0] <= req_in.wdata[dac_load_mask_offset_pkg::LOAD_CMD_REF_AB];
      ref_internal_ff[1] <= req_in.wdata[dac_load_mask_offset_pkg::LOAD_CMD_REF_CD];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_one_ff <= dac_load_mask_offset_pkg::RST_ZERO;
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_IRQ_GATE_ONE)) begin
      gate_one_ff <= req_in.wdata;
    end
  end

  // Reserved bits are expected zero; they are dropped so they cannot gate anything
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_two_ff <= dac_load_mask_offset_pkg::RST_ZERO;
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_IRQ_GATE_TWO)) begin
      gate_two_ff <= req_in.wdata & dac_load_mask_offset_pkg::GATE_TWO_USED;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_cal_ff <= dac_load_mask_offset_pkg::RST_ZERO;
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_INT_TEMP_CAL)) begin
      int_cal_ff <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cal_ff <= dac_load_mask_offset_pkg::RST_ZERO;
    end else if (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_EXT_TEMP_CAL)) begin
      ext_cal_ff <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      thermal_shift_ff <= dac_load_mask_offset_pkg::RST_THERMAL_SHIFT;
    end else if (req_in.wr &&
                 (req_in.addr == dac_load_mask_offset_pkg::ADDR_INT_THERMAL_SHIFT)) begin
      thermal_shift_ff <= req_in.wdata;
    end
  end

  // ==========================================================================
  // DAC load pulses
  // The pin passes two flops; the edge detector compares the second one with its delayed copy in pin_last_ff
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sync_ff <= '1;
      pin_last_ff <= 1'b1;
    end else begin
      pin_sync_ff <= {pin_sync_ff[SYNC_STAGES_W-2:0], load_pin_n_in};
      pin_last_ff <= pin_sync_ff[SYNC_STAGES_W-1];
    end
  end

  assign pin_fall = pin_last_ff && !pin_sync_ff[SYNC_STAGES_W-1];

  // Each bit loads only its own DAC; all set bits fire in the same cycle
  always_comb begin
    nxt_dac_load = 4'h0;
    if (wr_load_cmd && sw_load_enabled) begin
      nxt_dac_load = req_in.wdata[dac_load_mask_offset_pkg::LOAD_CMD_DAC_LSB +: 4];
    end
    if (!pin_disable_ff && pin_fall) begin
      nxt_dac_load = 4'hF;
    end
  end

  // Load bits are pulses, never stored, so read-back gives zero there
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dac_load_ff <= 4'h0;
    end else begin
      dac_load_ff <= nxt_dac_load;
    end
  end

  // ==========================================================================
  // Interrupt status, write one to clear; a new event wins over the clear
  assign clr_one = (req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_IRQ_STATUS_ONE))
                   ? req_in.wdata : 8'h00;
  assign clr_two = req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_IRQ_STATUS_TWO) &&
                   req_in.wdata[dac_load_mask_offset_pkg::GATE_TWO_SUPPLY];

  for (genvar i = 0; i < 8; i++) begin : g_status_one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        status_one_ff[i] <= 1'b0;
      end else if (events_in.upper_limit_events[i]) begin
        status_one_ff[i] <= 1'b1;
      end else if (clr_one[i]) begin
        status_one_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_two_ff <= 1'b0;
    end else if (events_in.supply_event) begin
      status_two_ff <= 1'b1;
    end else if (clr_two) begin
      status_two_ff <= 1'b0;
    end
  end

  // A gate bit of one blocks its event; zero lets it drive the output
  assign irq_out = (|(status_one_ff & ~gate_one_ff)) ||
                   (status_two_ff &&
                    !gate_two_ff[dac_load_mask_offset_pkg::GATE_TWO_SUPPLY]);

  // ==========================================================================
  // Temperature correction, saturating so a large offset cannot wrap
  always_comb begin
    int_sum = SUM_W'(int_temp_raw_in) + SUM_W'({{(TEMP_W-8){int_cal_ff[7]}}, int_cal_ff, 2'b00});
    ext_sum = SUM_W'(ext_temp_raw_in) + SUM_W'({{(TEMP_W-8){ext_cal_ff[7]}}, ext_cal_ff, 2'b00});
    if (int_sum > TEMP_MAX) begin
      int_corr = TEMP_MAX[TEMP_W-1:0];
    end else if (int_sum < TEMP_MIN) begin
      int_corr = TEMP_MIN[TEMP_W-1:0];
    end else begin
      int_corr = int_sum[TEMP_W-1:0];
    end
    if (ext_sum > TEMP_MAX) begin
      ext_corr = TEMP_MAX[TEMP_W-1:0];
    end else if (ext_sum < TEMP_MIN) begin
      ext_corr = TEMP_MIN[TEMP_W-1:0];
    end else begin
      ext_corr = ext_sum[TEMP_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_temp_ff  <= '0;
      int_valid_ff <= 1'b0;
    end else begin
      int_valid_ff <= int_temp_valid_in;
      if (int_temp_valid_in) begin
        int_temp_ff <= int_corr;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_temp_ff  <= '0;
      ext_valid_ff <= 1'b0;
    end else begin
      ext_valid_ff <= ext_temp_valid_in;
      if (ext_temp_valid_in) begin
        ext_temp_ff <= ext_corr;
      end
    end
  end

  // ==========================================================================
  // DAC A thermal code from whole degrees of the corrected internal result
  always_comb begin
    // Whole degrees keep their sign, so cold readings do not wrap to hot codes
    shifted_deg = 10'($signed(int_corr[TEMP_W-1:2])) +
                  {{2{thermal_shift_ff[7]}}, thermal_shift_ff};
    if ((shifted_deg > 10'sh07F) || (shifted_deg < 10'sh380)) begin
      nxt_thermal_code = dac_load_mask_offset_pkg::DEADBAND_CODE;
    end else begin
      nxt_thermal_code = shifted_deg[7:0] ^ dac_load_mask_offset_pkg::CODE_MIDSCALE_FLIP;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      thermal_code_ff <= dac_load_mask_offset_pkg::RST_ZERO;
    end else if (int_temp_valid_in) begin
      thermal_code_ff <= nxt_thermal_code;
    end
  end

  // ==========================================================================
  // Read path, data in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (req_in.addr)
      dac_load_mask_offset_pkg::ADDR_DAC_CONFIG:
        nxt_rdata = {2'b00, load_mode_ff, 4'h0};
      dac_load_mask_offset_pkg::ADDR_DAC_LOAD_CMD:
        nxt_rdata = {2'b00, ref_internal_ff, 4'h0};
      dac_load_mask_offset_pkg::ADDR_IRQ_GATE_ONE:      nxt_rdata = gate_one_ff;
      dac_load_mask_offset_pkg::ADDR_IRQ_GATE_TWO:      nxt_rdata = gate_two_ff;
      dac_load_mask_offset_pkg::ADDR_INT_TEMP_CAL:      nxt_rdata = int_cal_ff;
      dac_load_mask_offset_pkg::ADDR_EXT_TEMP_CAL:      nxt_rdata = ext_cal_ff;
      dac_load_mask_offset_pkg::ADDR_INT_THERMAL_SHIFT: nxt_rdata = thermal_shift_ff;
      dac_load_mask_offset_pkg::ADDR_CONTROL_THREE:
        nxt_rdata = {4'h0, pin_disable_ff, 3'h0};
      dac_load_mask_offset_pkg::ADDR_IRQ_STATUS_ONE:    nxt_rdata = status_one_ff;
      dac_load_mask_offset_pkg::ADDR_IRQ_STATUS_TWO:
        nxt_rdata = {3'h0, status_two_ff, 4'h0};
      default:                                          nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else if (req_in.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_out              = rdata_ff;
  assign dac_load_out           = dac_load_ff;
  assign ref_internal_out       = ref_internal_ff;
  assign int_temp_out           = int_temp_ff;
  assign int_temp_valid_out     = int_valid_ff;
  assign ext_temp_out           = ext_temp_ff;
  assign ext_temp_valid_out     = ext_valid_ff;
  assign dac_a_thermal_code_out = thermal_code_ff;

endmodule : dac_load_mask_offset_regs

// *** bench/load_bank_sva.sv ***
/*
  Assertions for the DAC load, interrupt gate and offset register bank.
  Assumes a single clk_in domain; it sees only the bank's ports.
*/
module load_bank_sva (
  // Clock and reset
  input wire logic                                    clk_in,
  input wire logic                                    rst_n_in,
  // Watched ports
  input wire dac_load_mask_offset_pkg::reg_req_t      req_in,
  input wire logic [7:0]                              rdata_out,
  input wire dac_load_mask_offset_pkg::limit_events_t events_in,
  input wire logic                                    load_pin_n_in,
  input wire logic                                    int_temp_valid_in,
  input wire logic                                    ext_temp_valid_in,
  input wire logic                                    int_temp_valid_out,
  input wire logic                                    ext_temp_valid_out,
  input wire logic [3:0]                              dac_load_out,
  input wire logic [1:0]                              ref_internal_out,
  input wire logic                                    irq_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Shadow of the registers that decide the expectations
  logic [1:0] mode_ff;
  logic       pin_off_ff;
  logic [7:0] gate_one_ff;
  logic       gate_two_ff;
  logic       wr_cmd;

  assign wr_cmd = req_in.wr && (req_in.addr == dac_load_mask_offset_pkg::ADDR_DAC_LOAD_CMD);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_ff     <= 2'h0;
      pin_off_ff  <= 1'b0;
      gate_one_ff <= 8'h00;
      gate_two_ff <= 1'b0;
    end else if (req_in.wr) begin
      case (req_in.addr)
        dac_load_mask_offset_pkg::ADDR_DAC_CONFIG:    mode_ff     <= req_in.wdata[5:4];
        dac_load_mask_offset_pkg::ADDR_CONTROL_THREE: pin_off_ff  <= req_in.wdata[3];
        dac_load_mask_offset_pkg::ADDR_IRQ_GATE_ONE:  gate_one_ff <= req_in.wdata;
        dac_load_mask_offset_pkg::ADDR_IRQ_GATE_TWO:  gate_two_ff <= req_in.wdata[4];
        default: ;
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================================
  // Assertions
  a_sw_load_fires: assert property (wr_cmd && mode_ff == 2'h3 && pin_off_ff
    |=> dac_load_out == $past(req_in.wdata[3:0])) else $error("software load mismatch");
  a_sw_load_blocked: assert property (wr_cmd && mode_ff != 2'h3 && pin_off_ff
    |=> dac_load_out == 4'h0) else $error("load outside register mode");
  a_ref_select: assert property (wr_cmd
    |=> ref_internal_out == $past(req_in.wdata[5:4])) else $error("reference select wrong");
  a_ref_hold_steady: assert property (!wr_cmd |=> $stable(ref_internal_out))
    else $error("reference changed without write");
  a_load_bits_clear: assert property (
    req_in.rd && req_in.addr == dac_load_mask_offset_pkg::ADDR_DAC_LOAD_CMD
    |=> rdata_out[3:0] == 4'h0) else $error("load bits read nonzero");
  a_irq_gate_one: assert property ((|(events_in.upper_limit_events & ~gate_one_ff))
    |=> irq_out) else $error("unmasked event gave no interrupt");
  a_irq_supply_open: assert property (events_in.supply_event && !gate_two_ff
    |=> irq_out) else $error("supply event gave no interrupt");
  a_pin_load_all: assert property ($fell(load_pin_n_in) && !pin_off_ff
    |-> ##[1:6] dac_load_out == 4'hF) else $error("pin load missing");
  a_temp_valid_lag: assert property (
    1'b1 |=> int_temp_valid_out == $past(int_temp_valid_in)
    && ext_temp_valid_out == $past(ext_temp_valid_in)) else $error("temp valid lag wrong");

  c_sw_load: cover property (wr_cmd && mode_ff == 2'h3 && pin_off_ff);
  c_irq_rise: cover property ($rose(irq_out));
  c_pin_load: cover property ($fell(load_pin_n_in) && !pin_off_ff);
endmodule : load_bank_sva

bind dac_load_mask_offset_regs load_bank_sva load_bank_sva_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in), .rdata_out(rdata_out),
  .events_in(events_in), .load_pin_n_in(load_pin_n_in),
  .int_temp_valid_in(int_temp_valid_in), .ext_temp_valid_in(ext_temp_valid_in),
  .int_temp_valid_out(int_temp_valid_out), .ext_temp_valid_out(ext_temp_valid_out),
  .dac_load_out(dac_load_out), .ref_internal_out(ref_internal_out), .irq_out(irq_out));

// *** bench/host_bus_model.sv ***
/*
  Host side of the register port: one-cycle write and read strobes.
  Assumes the bank answers a read in the cycle after the strobe.
*/
module host_bus_model (
  // Clock
  input  wire logic                               clk_in,
  // Register port
  input  wire logic [7:0]                         rdata_in,
  output dac_load_mask_offset_pkg::reg_req_t      req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_out = '0;

  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] clean;
    clean = data;
    // Reserved bits of 1C and 1E always go out as zeros
    if (addr == 8'h1C) clean = clean & 8'h3F;
    if (addr == 8'h1E) clean = clean & 8'h10;
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: clean};
    @(posedge clk_in);
    req_out <= '0;
  endtask : write

  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_in);
    req_out <= '0;
    @(posedge clk_in);
    data = rdata_in;
  endtask : read
endmodule : host_bus_model

// *** bench/dac_load_mask_offset_regs_tb.sv ***
/*
  Self-checking bench for the register bank, driven through the host model.
  Assumes a 200 MHz clock and the bank's default temperature width of 10.
*/
module dac_load_mask_offset_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                    clk_in = 1'b0;
  logic                                    rst_n_in = 1'b0;
  dac_load_mask_offset_pkg::reg_req_t      req;
  logic [7:0]                              rdata;
  dac_load_mask_offset_pkg::limit_events_t events_in = '0;
  logic                                    load_pin_n_in = 1'b1;
  logic signed [9:0]                       int_raw = 10'h000, ext_raw = 10'h000;
  logic                                    int_vld = 1'b0, ext_vld = 1'b0;
  logic signed [9:0]                       int_temp, ext_temp;
  logic                                    int_vld_o, ext_vld_o, irq;
  logic [7:0]                              code;
  logic [3:0]                              dac_load;
  logic [1:0]                              ref_int;
  int                                      failures = 0;
  int                                      checks = 0;

  always #2.5 clk_in = ~clk_in;

  host_bus_model host_bus_model_inst (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));

  dac_load_mask_offset_regs dac_load_mask_offset_regs_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .rdata_out(rdata),
    .events_in(events_in), .load_pin_n_in(load_pin_n_in),
    .int_temp_raw_in(int_raw), .int_temp_valid_in(int_vld),
    .ext_temp_raw_in(ext_raw), .ext_temp_valid_in(ext_vld),
    .int_temp_out(int_temp), .int_temp_valid_out(int_vld_o),
    .ext_temp_out(ext_temp), .ext_temp_valid_out(ext_vld_o),
    .dac_a_thermal_code_out(code), .dac_load_out(dac_load),
    .ref_internal_out(ref_int), .irq_out(irq));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_bus_model_inst.write(a, d);
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_bus_model_inst.read(a, d);
    check($sformatf("reg %0h", a), d, e);
  endtask : rd_chk

  task automatic pulse(input logic [7:0] up, input logic sup);
    @(posedge clk_in);
    events_in <= '{upper_limit_events: up, supply_event: sup};
    @(posedge clk_in);
    events_in <= '0;
    #1;
  endtask : pulse

  task automatic temp(input logic signed [9:0] ri, input logic signed [9:0] re);
    @(posedge clk_in);
    {int_raw, ext_raw, int_vld, ext_vld} <= {ri, re, 2'h3};
    @(posedge clk_in);
    {int_vld, ext_vld} <= 2'h0;
    #1;
  endtask : temp

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    rd_chk(8'h1D, 8'h00);
    rd_chk(8'h1E, 8'h00);
    rd_chk(8'h1F, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h21, 8'hD8);
    rd_chk(8'h1C, 8'h00);
    rd_chk(8'h05, 8'h00);
    check("irq", irq, 10'h000);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_sw_load();
    int seen;
    wr(8'h30, 8'h08);
    wr(8'h1B, 8'h00);
    wr(8'h1C, 8'h3F);
    check("load off mode", dac_load, 10'h000);
    check("ref both", ref_int, 10'h003);
    wr(8'h1B, 8'h30);
    for (int n = 0; n < 4; n++) begin
      wr(8'h1C, 8'h10 | (8'h01 << n));
      check("load one", dac_load, 10'h001 << n);
      check("ref ab", ref_int, 10'h001);
    end
    wr(8'h1C, 8'h2F);
    check("load all", dac_load, 10'h00F);
    check("ref cd", ref_int, 10'h002);
    rd_chk(8'h1C, 8'h20);
    seen = 0;
    @(posedge clk_in) load_pin_n_in <= 1'b0;
    repeat (8) @(posedge clk_in) if (dac_load !== 4'h0) seen = 1;
    load_pin_n_in <= 1'b1;
    check("pin when off", seen[0], 10'h000);
    wr(8'h30, 8'h00);
    wr(8'h1C, 8'h01);
    check("sw with pin on", dac_load, 10'h000);
    @(posedge clk_in) load_pin_n_in <= 1'b0;
    repeat (8) @(posedge clk_in) if (dac_load === 4'hF) seen = 1;
    load_pin_n_in <= 1'b1;
    check("pin when on", seen[0], 10'h001);
    $display("test_sw_load done");
  endtask : test_sw_load

  task automatic test_irq();
    for (int i = 0; i < 8; i++) begin
      wr(8'h1D, ~(8'h01 << i));
      pulse(~(8'h01 << i), 1'b0);
      check("irq gated", irq, 10'h000);
      wr(8'h31, 8'hFF);
      pulse(8'h01 << i, 1'b0);
      check("irq open", irq, 10'h001);
      rd_chk(8'h31, 8'h01 << i);
      wr(8'h31, 8'hFF);
      check("irq cleared", irq, 10'h000);
    end
    wr(8'h1D, 8'hFF);
    wr(8'h1E, 8'h10);
    pulse(8'h00, 1'b1);
    check("supply gated", irq, 10'h000);
    wr(8'h32, 8'h10);
    wr(8'h1E, 8'h00);
    pulse(8'h00, 1'b1);
    check("supply open", irq, 10'h001);
    wr(8'h32, 8'h10);
    check("supply cleared", irq, 10'h000);
    $display("test_irq done");
  endtask : test_irq

  task automatic test_temp();
    wr(8'h1F, 8'h02);
    wr(8'h20, 8'hFE);
    rd_chk(8'h20, 8'hFE);
    temp(10'h064, 10'h3D8);
    check("int temp", int_temp, 10'h06C);
    check("ext temp", ext_temp, 10'h3D0);
    check("code", code, 10'h073);
    wr(8'h21, 8'h7F);
    temp(10'h064, 10'h000);
    check("code high", code, 10'h0FF);
    wr(8'h21, 8'h80);
    temp(10'h3F4, 10'h000);
    check("code low", code, 10'h0FF);
    $display("test_temp done");
  endtask : test_temp

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_sw_load();
    test_irq();
    test_temp();
    test_done();
  end

  // Far above the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    test_done();
  end
endmodule : dac_load_mask_offset_regs_tb
